//--- logic/pam_port_mux.sv
`timescale 1ns/1ps
module pam_port_mux
    import pam_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [pam_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pam_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sleep controller
    input wire logic sleep_clamp,
    // First port pads
    input wire logic [7:0] pa_pad_in,
    output logic [7:0] pa_drive_en,
    output logic [7:0] pa_drive_val,
    output logic [7:0] pa_pullup_en,
    output logic [7:0] pa_input_en,
    output logic [7:0] conv_in_ch,
    // Second port pads
    input wire logic [7:0] pb_pad_in,
    output logic [7:0] pb_drive_en,
    output logic [7:0] pb_drive_val,
    output logic [7:0] pb_pullup_en,
    output logic [7:0] pb_input_en,
    // Serial peripheral interface
    input wire logic serial_periph_enable,
    input wire logic serial_master_select,
    input wire logic spi_sck_out,
    input wire logic spi_slave_out,
    input wire logic spi_master_out,
    output logic spi_sck_in,
    output logic spi_master_in,
    output logic spi_slave_in,
    output logic spi_select_n_in,
    // Timers, interrupt, comparator
    input wire logic timer0_compare_en,
    input wire logic timer0_compare_out,
    input wire logic ext_irq2_en,
    output logic ext_irq2_in,
    output logic timer1_count_in,
    output logic timer0_count_in,
    output logic comparator_pos_in,
    output logic comparator_neg_in,
    // Synchronous serial clock
    input wire logic sync_mode_select,
    input wire logic sync_serial_clk_out,
    output logic sync_serial_clk_in
);
    import pam_pkg::*;

    logic [7:0] porta_out, porta_dir, portb_out, portb_dir;
    logic global_pullup_disable;
    logic [7:0] pa_sync1, pa_sync2, pb_sync1, pb_sync2;
    logic [7:0] pa_di, pb_di;
    pam_wr_state_t wr_state;
    pam_rd_state_t rd_state;
    logic aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;

    // Second-port overrides
    logic [3:0] spi_pullup_override_en, spi_pullup_override_val, spi_dir_override_en, spi_value_override_en, spi_value_override_val;
    wire [7:0] pb_pullup_override_en = {spi_pullup_override_en, 4'h0};
    wire [7:0] pb_pullup_override_val = {spi_pullup_override_val, 4'h0};
    wire [7:0] pb_dir_override_en = {spi_dir_override_en, 4'h0};
    wire [7:0] pb_value_override_en = {spi_value_override_en, timer0_compare_en, 2'h0, sync_mode_select};
    wire [7:0] pb_value_override_val = {spi_value_override_val, timer0_compare_out, 2'h0, sync_serial_clk_out};
    wire [7:0] pb_input_en_override_en = {5'h00, ext_irq2_en, 2'h0};
    wire [7:0] pb_input_en_override_val = 8'h04;

    pam_spi_ovr u_spi (
        .serial_periph_enable(serial_periph_enable),
        .serial_master_select(serial_master_select),
        .out_bit(portb_out[7:4]),
        .global_pullup_disable(global_pullup_disable),
        .sck_out(spi_sck_out),
        .slave_data_out(spi_slave_out),
        .master_data_out(spi_master_out),
        .pullup_override_en(spi_pullup_override_en),
        .pullup_override_val(spi_pullup_override_val),
        .dir_override_en(spi_dir_override_en),
        .value_override_en(spi_value_override_en),
        .value_override_val(spi_value_override_val)
    );

    // All first-port overrides tied inactive
    pam_pin_cell u_pa (
        .dir(porta_dir),
        .out_bit(porta_out),
        .global_pullup_disable(global_pullup_disable),
        .sleep_clamp(sleep_clamp),
        .pullup_override_en(8'h00),
        .pullup_override_val(8'h00),
        .dir_override_en(8'h00),
        .dir_override_val(8'h00),
        .value_override_en(8'h00),
        .value_override_val(8'h00),
        .input_en_override_en(8'h00),
        .input_en_override_val(8'h00),
        .pad_in(pa_pad_in),
        .drive_en(pa_drive_en),
        .drive_val(pa_drive_val),
        .pullup_en(pa_pullup_en),
        .input_en(pa_input_en),
        .raw_digital_in(pa_di)
    );

    // Direction overrides only ever force inputs here
    pam_pin_cell u_pb (
        .dir(portb_dir),
        .out_bit(portb_out),
        .global_pullup_disable(global_pullup_disable),
        .sleep_clamp(sleep_clamp),
        .pullup_override_en(pb_pullup_override_en),
        .pullup_override_val(pb_pullup_override_val),
        .dir_override_en(pb_dir_override_en),
        .dir_override_val(8'h00),
        .value_override_en(pb_value_override_en),
        .value_override_val(pb_value_override_val),
        .input_en_override_en(pb_input_en_override_en),
        .input_en_override_val(pb_input_en_override_val),
        .pad_in(pb_pad_in),
        .drive_en(pb_drive_en),
        .drive_val(pb_drive_val),
        .pullup_en(pb_pullup_en),
        .input_en(pb_input_en),
        .raw_digital_in(pb_di)
    );

    // Peripheral inputs are unsynchronised; each peripheral syncs its own
    assign conv_in_ch = pa_pad_in;
    assign spi_sck_in = pb_di[PIN_SCK];
    assign spi_master_in = pb_di[PIN_MISO];
    assign spi_slave_in = pb_di[PIN_MOSI];
    assign spi_select_n_in = pb_di[PIN_SEL];
    assign comparator_neg_in = pb_pad_in[PIN_OC0];
    assign comparator_pos_in = pb_pad_in[PIN_IRQ2];
    assign ext_irq2_in = pb_di[PIN_IRQ2];
    assign timer1_count_in = pb_di[PIN_T1];
    assign timer0_count_in = pb_di[PIN_XCK];
    assign sync_serial_clk_in = pb_di[PIN_XCK] & sync_mode_select;

    // Pin readback synchronisers
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            pa_sync1 <= RST_PORT;
            pa_sync2 <= RST_PORT;
            pb_sync1 <= RST_PORT;
            pb_sync2 <= RST_PORT;
        end
        else if (ce)
        begin
            pa_sync1 <= pa_di;
            pa_sync2 <= pa_sync1;
            pb_sync1 <= pb_di;
            pb_sync2 <= pb_sync1;
        end
    end

    // Write channel: address and data taken in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
    wire [7:0] wr_data = w_held ? w_data_q : s_axi_wdata[7:0];
    wire wr_lane0 = w_held ? w_strb_q : s_axi_wstrb[0];
    wire wr_both = (wr_state == WS_COLLECT) & (aw_held | aw_take) & (w_held | w_take);
    wire pam_sel_t wr_sel = pam_reg_sel(wr_addr);
    wire wr_fire = ce & wr_both & wr_lane0;
    assign s_axi_awready = ce & (wr_state == WS_COLLECT) & ~aw_held;
    assign s_axi_wready = ce & (wr_state == WS_COLLECT) & ~w_held;
    assign s_axi_bvalid = (wr_state == WS_RESP);
    assign s_axi_bresp = bresp_q;

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            wr_state <= WS_COLLECT;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (aw_take)
                aw_addr_q <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
            unique case (wr_state)
                WS_COLLECT:
                begin
                    if (wr_both)
                    begin
                        wr_state <= WS_RESP;
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                    end
                    else
                    begin
                        aw_held <= aw_held | aw_take;
                        w_held <= w_held | w_take;
                    end
                end
                WS_RESP:
                begin
                    if (s_axi_bready)
                        wr_state <= WS_COLLECT;
                end
                default: wr_state <= WS_COLLECT;
            endcase
        end
    end

    // Port registers; read-only offsets ignore writes
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            porta_out <= RST_PORT;
            porta_dir <= RST_PORT;
            portb_out <= RST_PORT;
            portb_dir <= RST_PORT;
            global_pullup_disable <= RST_PUD;
        end
        else if (wr_fire)
        begin
            if (wr_sel == SEL_PA_OUT)
                porta_out <= wr_data;
            if (wr_sel == SEL_PA_DIR)
                porta_dir <= wr_data;
            if (wr_sel == SEL_PB_OUT)
                portb_out <= wr_data;
            if (wr_sel == SEL_PB_DIR)
                portb_dir <= wr_data;
            if (wr_sel == SEL_CTRL)
                global_pullup_disable <= wr_data[CTRL_PUD_BIT];
        end
    end

    // Read channel
    wire pam_sel_t rd_sel = pam_reg_sel(s_axi_araddr);
    wire [31:0] stat_word = {pb_input_en_override_en, pb_pullup_override_en, pb_value_override_en, pb_dir_override_en};
    wire [31:0] rd_word =
        (rd_sel == SEL_PA_OUT) ? {24'h000000, porta_out} :
        (rd_sel == SEL_PA_DIR) ? {24'h000000, porta_dir} :
        (rd_sel == SEL_PA_PIN) ? {24'h000000, pa_sync2} :
        (rd_sel == SEL_PB_OUT) ? {24'h000000, portb_out} :
        (rd_sel == SEL_PB_DIR) ? {24'h000000, portb_dir} :
        (rd_sel == SEL_PB_PIN) ? {24'h000000, pb_sync2} :
        (rd_sel == SEL_CTRL) ? {31'h00000000, global_pullup_disable} :
        (rd_sel == SEL_STAT) ? stat_word : 32'h00000000;
    assign s_axi_arready = ce & (rd_state == RS_IDLE);
    assign s_axi_rvalid = (rd_state == RS_DATA);
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            rd_state <= RS_IDLE;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end
        else if (ce)
        begin
            unique case (rd_state)
                RS_IDLE:
                begin
                    if (s_axi_arvalid)
                    begin
                        rd_state <= RS_DATA;
                        rdata_q <= rd_word;
                        rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
                    end
                end
                RS_DATA:
                begin
                    if (s_axi_rready)
                        rd_state <= RS_IDLE;
                end
                default: rd_state <= RS_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    wire as_slave = serial_periph_enable & ~serial_master_select;
    wire as_master = serial_periph_enable & serial_master_select;

    a_porta_inert: assert property (
        pa_drive_en == porta_dir && pa_drive_val == porta_out
        && pa_input_en == {8{~sleep_clamp}} && conv_in_ch == pa_pad_in)
        else $error("first port took an override");
    a_sck_forced: assert property (
        (as_slave |-> !pb_drive_en[PIN_SCK])
        and (as_master |-> pb_drive_en[PIN_SCK] == portb_dir[PIN_SCK]))
        else $error("clock pin direction wrong");
    a_miso_forced: assert property (as_master |-> !pb_drive_en[PIN_MISO])
        else $error("data-in pin driven as master");
    a_mosi_forced: assert property (as_slave |-> !pb_drive_en[PIN_MOSI])
        else $error("data-out pin driven as slave");
    a_select_pin: assert property (
        as_master |-> pb_drive_en[PIN_SEL] == portb_dir[PIN_SEL]
        && pb_drive_val[PIN_SEL] == portb_out[PIN_SEL])
        else $error("select pin overridden as master");
    a_forced_pullup: assert property (
        as_slave |-> pb_pullup_en[PIN_SCK]
        == (portb_out[PIN_SCK] & ~global_pullup_disable))
        else $error("forced input pull-up wrong");
    a_sck_value: assert property (
        as_master && portb_dir[PIN_SCK]
        |-> pb_drive_val[PIN_SCK] == spi_sck_out)
        else $error("clock value not from serial block");
    a_oc0_drive: assert property (
        timer0_compare_en && portb_dir[PIN_OC0]
        |-> pb_drive_en[PIN_OC0] && pb_drive_val[PIN_OC0] == timer0_compare_out)
        else $error("compare output not driven");
    a_irq2_awake: assert property (
        ext_irq2_en && sleep_clamp
        |-> pb_input_en[PIN_IRQ2] && ext_irq2_in == pb_pad_in[PIN_IRQ2])
        else $error("interrupt input clamped");
    a_xck_gate: assert property (
        !sync_mode_select |-> !sync_serial_clk_in
        && pb_drive_val[PIN_XCK] == portb_out[PIN_XCK])
        else $error("sync clock active outside sync mode");
    a_default_pullup: assert property (
        !serial_periph_enable |-> pb_pullup_en
        == (~portb_dir & portb_out & {8{~global_pullup_disable}}))
        else $error("default pull-up pattern wrong");

    sequence s_wr_ctrl;
        ce && wr_fire && wr_sel == SEL_CTRL;
    endsequence
    sequence s_wr_done(logic v);
        s_axi_bvalid && global_pullup_disable == v;
    endsequence
    a_ctrl_write: assert property (s_wr_ctrl |=> s_wr_done($past(wr_data[CTRL_PUD_BIT])))
        else $error("control write did not land");
endmodule : pam_port_mux

//--- pkg/pam_pkg.sv
package pam_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFS_PA_OUT = 8'h00;
    localparam logic [7:0] OFS_PA_DIR = 8'h04;
    localparam logic [7:0] OFS_PA_PIN = 8'h08;
    localparam logic [7:0] OFS_PB_OUT = 8'h0C;
    localparam logic [7:0] OFS_PB_DIR = 8'h10;
    localparam logic [7:0] OFS_PB_PIN = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_OVR_STAT = 8'h1C;
    // Reset values and field positions
    localparam logic [7:0] RST_PORT = 8'h00;
    localparam logic RST_PUD = 1'b0;
    localparam int CTRL_PUD_BIT = 0;
    localparam int PIN_SCK = 7;
    localparam int PIN_MISO = 6;
    localparam int PIN_MOSI = 5;
    localparam int PIN_SEL = 4;
    localparam int PIN_OC0 = 3;
    localparam int PIN_IRQ2 = 2;
    localparam int PIN_T1 = 1;
    localparam int PIN_XCK = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        SEL_PA_OUT = 4'h1, SEL_PA_DIR = 4'h2, SEL_PA_PIN = 4'h3, SEL_PB_OUT = 4'h4,
        SEL_PB_DIR = 4'h5, SEL_PB_PIN = 4'h6, SEL_CTRL = 4'h7, SEL_STAT = 4'h8,
        SEL_NONE = 4'h0
    } pam_sel_t;
    typedef enum logic [1:0] {WS_COLLECT = 2'b01, WS_RESP = 2'b10} pam_wr_state_t;
    typedef enum logic [1:0] {RS_IDLE = 2'b01, RS_DATA = 2'b10} pam_rd_state_t;

    function automatic pam_sel_t pam_reg_sel(input logic [ADDR_W-1:0] a);
        unique case (a)
            OFS_PA_OUT: pam_reg_sel = SEL_PA_OUT;
            OFS_PA_DIR: pam_reg_sel = SEL_PA_DIR;
            OFS_PA_PIN: pam_reg_sel = SEL_PA_PIN;
            OFS_PB_OUT: pam_reg_sel = SEL_PB_OUT;
            OFS_PB_DIR: pam_reg_sel = SEL_PB_DIR;
            OFS_PB_PIN: pam_reg_sel = SEL_PB_PIN;
            OFS_CTRL: pam_reg_sel = SEL_CTRL;
            OFS_OVR_STAT: pam_reg_sel = SEL_STAT;
            default: pam_reg_sel = SEL_NONE;
        endcase
    endfunction : pam_reg_sel
endpackage : pam_pkg

//--- logic/pam_pin_cell.sv
`timescale 1ns/1ps
module pam_pin_cell (
    // Port register bits
    input wire logic [7:0] dir,
    input wire logic [7:0] out_bit,
    input wire logic global_pullup_disable,
    input wire logic sleep_clamp,
    // Overrides from peripherals
    input wire logic [7:0] pullup_override_en,
    input wire logic [7:0] pullup_override_val,
    input wire logic [7:0] dir_override_en,
    input wire logic [7:0] dir_override_val,
    input wire logic [7:0] value_override_en,
    input wire logic [7:0] value_override_val,
    input wire logic [7:0] input_en_override_en,
    input wire logic [7:0] input_en_override_val,
    // Pads
    input wire logic [7:0] pad_in,
    output logic [7:0] drive_en,
    output logic [7:0] drive_val,
    output logic [7:0] pullup_en,
    output logic [7:0] input_en,
    output logic [7:0] raw_digital_in
);
    wire [7:0] pud_n = {8{~global_pullup_disable}};
    wire [7:0] awake = {8{~sleep_clamp}};

    assign pullup_en = (pullup_override_en & pullup_override_val)
        | (~pullup_override_en & ~dir & out_bit & pud_n);
    assign drive_en = (dir_override_en & dir_override_val)
        | (~dir_override_en & dir);
    // Value is only seen on the pad while the driver is on
    assign drive_val = (value_override_en & value_override_val)
        | (~value_override_en & out_bit);
    assign input_en = (input_en_override_en & input_en_override_val)
        | (~input_en_override_en & awake);
    // Clamped input reads low, as the schmitt trigger does in sleep
    assign raw_digital_in = pad_in & input_en;
endmodule : pam_pin_cell

//--- logic/pam_spi_ovr.sv
`timescale 1ns/1ps
module pam_spi_ovr (
    // Serial interface mode
    input wire logic serial_periph_enable,
    input wire logic serial_master_select,
    // Port bits 7..4
    input wire logic [3:0] out_bit,
    input wire logic global_pullup_disable,
    // Serial outputs: clock, slave data, master data
    input wire logic sck_out,
    input wire logic slave_data_out,
    input wire logic master_data_out,
    // Overrides for pins 7..4
    output logic [3:0] pullup_override_en,
    output logic [3:0] pullup_override_val,
    output logic [3:0] dir_override_en,
    output logic [3:0] value_override_en,
    output logic [3:0] value_override_val
);
    wire as_master = serial_periph_enable & serial_master_select;
    wire as_slave = serial_periph_enable & ~serial_master_select;
    // Forced inputs: clock, data in and select as slave, data in as master
    wire [3:0] forced_in = {as_slave, as_master, as_slave, as_slave};

    assign dir_override_en = forced_in;
    assign pullup_override_en = forced_in;
    assign pullup_override_val = out_bit & {4{~global_pullup_disable}};
    // Select pin never gets a value override
    assign value_override_en = {as_master, as_slave, as_master, 1'b0};
    assign value_override_val = {sck_out, slave_data_out, master_data_out, 1'b0};
endmodule : pam_spi_ovr

//--- tb/pam_periph_model.sv
`timescale 1ns/1ps
module pam_periph_model (
    // Clock and pattern from the bench
    input wire logic clock,
    input wire logic [4:0] pat,
    // Peripheral outputs toward the pin mux
    output logic spi_sck_out,
    output logic spi_slave_out,
    output logic spi_master_out,
    output logic timer0_compare_out,
    output logic sync_serial_clk_out
);
    // Registered, so values move only after an edge, as real peripheral flops do
    always_ff @(posedge clock)
        {sync_serial_clk_out, timer0_compare_out, spi_master_out, spi_slave_out,
            spi_sck_out} <= pat;
endmodule : pam_periph_model

//--- tb/pam_port_mux_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module pam_port_mux_test;
    import pam_pkg::*;
    logic clock = 0, nrst = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, sleep_clamp = 0, serial_periph_enable = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pa_pad_in = 8'h3C, pb_pad_in = 8'hA5;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] pa_drive_en, pa_drive_val, pa_pullup_en, pa_input_en, conv_in_ch;
    logic [7:0] pb_drive_en, pb_drive_val, pb_pullup_en, pb_input_en;
    logic serial_master_select = 0, timer0_compare_en = 0, ext_irq2_en = 0;
    logic sync_mode_select = 0, spi_sck_out, spi_slave_out, spi_master_out;
    logic timer0_compare_out, sync_serial_clk_out, spi_sck_in, spi_master_in, spi_slave_in;
    logic spi_select_n_in, ext_irq2_in, timer1_count_in, timer0_count_in;
    logic comparator_pos_in, comparator_neg_in, sync_serial_clk_in;
    logic [4:0] pat = 5'h00;
    int miscompares = 0, cmp_count = 0;
    pam_port_mux u_dut (.*);
    pam_periph_model u_per (.*);
    initial
    begin
        forever #2.5 clock = ~clock;
    end
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic tmo(input logic ok);
        if (!ok)
        begin
            miscompares++;
            close_out();
        end
    endtask : tmo
    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        tb = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !tb; n++)
        begin
            @(negedge clock);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            if (tb)
                `CHK(s_axi_bresp, er)
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
        tmo(tb);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tb;
        tb = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !tb; n++)
        begin
            @(negedge clock);
            ta = s_axi_arvalid && s_axi_arready;
            tb = s_axi_rvalid;
            if (tb)
                `CHK({s_axi_rdata, s_axi_rresp}, {ed, er})
            @(posedge clock);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tb) s_axi_rready <= 1'b0;
        end
        tmo(tb);
    endtask : axr
    task automatic t_reset();
        @(negedge clock);
        `CHK({pb_drive_en, pb_pullup_en, pa_drive_en}, 24'h0)
        axr(OFS_CTRL, 32'h0, RESP_OKAY);
        axr(8'h20, 32'h0, RESP_SLVERR);
        axw(8'h24, 8'hFF, RESP_SLVERR);
        axw(OFS_PB_PIN, 8'hFF, RESP_OKAY);
        axr(OFS_PB_PIN, 32'hA5, RESP_OKAY);
        // Lane 0 strobe low: answered OKAY, nothing written
        s_axi_wstrb <= 4'hE;
        axw(OFS_CTRL, 8'h01, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axr(OFS_CTRL, 32'h0, RESP_OKAY);
    endtask : t_reset
    task automatic t_porta();
        // Drive outputs stay steady afterwards; only the control writes move the pull-ups
        axw(OFS_PA_DIR, 8'hF0, RESP_OKAY);
        axw(OFS_PA_OUT, 8'hA5, RESP_OKAY);
        @(posedge clock);
        serial_periph_enable <= 1'b1;
        @(negedge clock);
        `CHK({pa_drive_en, pa_drive_val & 8'hF0}, 16'hF0A0)
        `CHK({pa_pullup_en, pa_input_en}, 16'h05FF)
        `CHK(conv_in_ch, pa_pad_in)
        axw(OFS_CTRL, 8'h01, RESP_OKAY);
        @(negedge clock);
        `CHK(pa_pullup_en, 8'h00)
        axw(OFS_CTRL, 8'h00, RESP_OKAY);
        serial_periph_enable <= 1'b0;
    endtask : t_porta
    task automatic t_spi(input logic m);
        axw(OFS_PB_DIR, 8'hFF, RESP_OKAY);
        axw(OFS_PB_OUT, 8'h7F, RESP_OKAY);
        serial_periph_enable <= 1'b1;
        serial_master_select <= m;
        pat <= 5'b00001;
        @(posedge clock);
        @(negedge clock);
        `CHK(pb_drive_en, m ? 8'hBF : 8'h4F)
        `CHK(pb_pullup_en, m ? 8'h40 : 8'h30)
        `CHK(pb_drive_val & pb_drive_en, m ? 8'h9F : 8'h0F)
        `CHK({spi_sck_in, spi_slave_in, spi_select_n_in, spi_master_in}, 4'hC)
        axr(OFS_OVR_STAT, m ? 32'h0040A040 : 32'h00B040B0, RESP_OKAY);
        axw(OFS_CTRL, 8'h01, RESP_OKAY);
        @(negedge clock);
        `CHK(pb_pullup_en, 8'h00)
        axw(OFS_CTRL, 8'h00, RESP_OKAY);
        serial_periph_enable <= 1'b0;
        @(negedge clock);
        `CHK(pb_drive_en, 8'hFF)
    endtask : t_spi
    task automatic t_timer();
        @(posedge clock);
        timer0_compare_en <= 1'b1;
        pat <= 5'b00000;
        @(posedge clock);
        @(negedge clock);
        `CHK({pb_drive_en[3], pb_drive_val[3]}, 2'b10)
        @(posedge clock);
        timer0_compare_en <= 1'b0;
        @(negedge clock);
        `CHK(pb_drive_val[3], 1'b1)
    endtask : t_timer
    task automatic t_irq();
        // Comparator pins left as inputs without pull-ups
        axw(OFS_PB_DIR, 8'h00, RESP_OKAY);
        axw(OFS_PB_OUT, 8'h00, RESP_OKAY);
        sleep_clamp <= 1'b1;
        @(negedge clock);
        `CHK({pb_input_en, ext_irq2_in}, 9'h000)
        `CHK({comparator_pos_in, comparator_neg_in, pb_pullup_en}, {2'b10, 8'h00})
        @(posedge clock);
        ext_irq2_en <= 1'b1;
        @(negedge clock);
        `CHK({pb_input_en, ext_irq2_in}, {8'h04, 1'b1})
        @(posedge clock);
        ext_irq2_en <= 1'b0;
        sleep_clamp <= 1'b0;
    endtask : t_irq
    task automatic t_xck();
        axw(OFS_PB_DIR, 8'h01, RESP_OKAY);
        sync_mode_select <= 1'b1;
        pat <= 5'b10000;
        @(posedge clock);
        @(negedge clock);
        `CHK({pb_drive_en[0], pb_drive_val[0]}, 2'b11)
        `CHK({timer0_count_in, timer1_count_in, sync_serial_clk_in}, 3'b101)
        axw(OFS_PB_DIR, 8'h00, RESP_OKAY);
        @(negedge clock);
        `CHK(pb_drive_en[0], 1'b0)
        axw(OFS_PB_DIR, 8'h01, RESP_OKAY);
        sync_mode_select <= 1'b0;
        @(negedge clock);
        `CHK({pb_drive_val[0], sync_serial_clk_in}, 2'b00)
    endtask : t_xck
    initial
    begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_porta();
        t_spi(1'b0);
        t_spi(1'b1);
        t_timer();
        t_irq();
        t_xck();
        close_out();
    end
endmodule : pam_port_mux_test
